// ==== design/flash_row_sequencer.sv ====
// self-programming sequencer: row erase, latch load and block commit
// assumes the core drives the register port and honours core_stall_o
// Notes on behaviour
// - running code erases only whole rows
// - trigger accepted only after 55h then aah
// - trigger starts erase; erase bit clears when done
// - two setup cycles before the core stalls
// - core stalls for erase time; clocks run
// - core resumes at third instruction after an erase trigger, fourth after a commit
// - program start never erases anything
// - commit stays inside one aligned latch block
// - latches return to 3fff after commit
// - latch-only trigger loads one latch, no programming
// - otherwise load final latch and program block
// - commit programs every latch, loaded or not
`timescale 1ns/1ps
module flash_row_sequencer
  import flash_seq_pkg::*;
#(
  parameter int LATCHES     = LATCH_COUNT,
  parameter int ERASE_COUNT = ERASE_CYCLES,
  parameter int PROG_COUNT  = PROG_CYCLES
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // register port
  input  wire reg_req_t              reg_req_i,
  output logic      [REG_DATA_W-1:0] reg_rdata_o,
  // core and flash array
  output logic                       core_stall_o,
  output flash_cmd_t                 flash_cmd_o
);

  // last value of each counter, one below the span it times
  localparam int IDX_W = $clog2(LATCHES);
  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_COUNT - 1);
  localparam logic [CNT_W-1:0] PROG_LAST  = CNT_W'(PROG_COUNT - 1);
  localparam logic [CNT_W-1:0] WORD_LAST  = CNT_W'(LATCHES - 1);

  // reset synchroniser: asserts at once, releases two edges later,
  // so every flop below leaves reset on the same clock edge
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_b = rst_sync_reg;

  // software-visible registers
  // high halves keep only the bits the address and word widths use
  logic [REG_DATA_W-1:0]  addr_low_reg;
  logic [ADDR_HIGH_W-1:0] addr_high_reg;
  logic [REG_DATA_W-1:0]  data_low_reg;
  logic [DATA_HIGH_W-1:0] data_high_reg;
  logic                   trigger_reg;
  logic                   permit_reg;
  logic                   erase_sel_reg;
  logic                   latch_only_reg;
  logic                   config_sel_reg;
  logic                   prog_space_reg;
  logic [REG_DATA_W-1:0]  rdata_reg;
  key_state_t             key_reg;
  key_state_t             key_next;

  // sequencer state
  // one counter times setup, the word stream and both waits
  seq_state_t             state_reg;
  seq_state_t             state_next;
  logic [CNT_W-1:0]       cnt_reg;
  logic [CNT_W-1:0]       cnt_next;
  logic                   stall_reg;
  flash_cmd_t             cmd_reg;
  flash_cmd_t             cmd_next;

  // register decode
  // strobe and address qualify each write; reads never change state
  wire idle_w       = (state_reg == ST_IDLE);
  wire wr_addr_lo_w = reg_req_i.we && reg_req_i.addr == OFS_ADDR_LOW;
  wire wr_addr_hi_w = reg_req_i.we && reg_req_i.addr == OFS_ADDR_HIGH;
  wire wr_data_lo_w = reg_req_i.we && reg_req_i.addr == OFS_DATA_LOW;
  wire wr_data_hi_w = reg_req_i.we && reg_req_i.addr == OFS_DATA_HIGH;
  wire wr_ctl_w     = reg_req_i.we && reg_req_i.addr == OFS_CONTROL;
  wire wr_key_w     = reg_req_i.we && reg_req_i.addr == OFS_UNLOCK;
  wire [REG_DATA_W-1:0] wd_w = reg_req_i.wdata;

  // a trigger counts only when the key pair came right before it
  // a refused trigger still stores the other control bits
  wire trig_ok_w = idle_w && wr_ctl_w && wd_w[CTL_TRIGGER_BIT]
                   && key_reg == KEY_OPEN
                   && wd_w[CTL_PERMIT_BIT] && wd_w[CTL_PROGSPACE_BIT]
                   && !wd_w[CTL_CONFIG_BIT];

  // address and block decomposition
  wire [PADDR_W-1:0] word_addr_w  = {addr_high_reg, addr_low_reg};
  wire [IDX_W-1:0]   latch_idx_w  = word_addr_w[IDX_W-1:0];
  wire [PADDR_W-1:0] block_base_w = {word_addr_w[PADDR_W-1:IDX_W],
                                     {IDX_W{1'b0}}};
  wire [PWORD_W-1:0] data_word_w  = {data_high_reg, data_low_reg};
  wire [IDX_W-1:0]   stream_idx_w = cnt_reg[IDX_W-1:0];
  wire [PWORD_W-1:0] latch_word_w;

  // latch controls
  // the clear lands on the last wait cycle, where no load can occur
  wire latch_load_w  = (state_reg == ST_LOAD);
  wire latch_clear_w = (state_reg == ST_PROG_WAIT) && cnt_reg == PROG_LAST;
  wire done_w        = (state_reg == ST_FINISH);

  // unlock key sequencer: 55h then aah, anything else relocks
  // reads leave the key alone; any other write relocks it
  // a first key byte restarts the pair, even from the half state
  always_comb begin
    key_next = key_reg;
    if (wr_key_w) begin
      if (wd_w == KEY_FIRST) begin
        key_next = KEY_HALF;
      end else if (wd_w == KEY_SECOND && key_reg == KEY_HALF) begin
        key_next = KEY_OPEN;
      end else begin
        key_next = KEY_LOCKED;
      end
    end else if (reg_req_i.we) begin
      key_next = KEY_LOCKED;
    end
  end

  // operation sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cmd_next   = '0;
    case (state_reg)
      // wait for an unlocked trigger
      ST_IDLE: begin
        cnt_next = '0;
        if (trig_ok_w) begin
          state_next = ST_SETUP;
        end
      end
      // two cycles in which the core still runs its idle slots
      ST_SETUP: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == SETUP_LAST) begin
          cnt_next = '0;
          if (erase_sel_reg) begin
            state_next = ST_ERASE;
          end else begin
            state_next = ST_LOAD;
          end
        end
      end
      // one erase command for the whole row
      ST_ERASE: begin
        cmd_next.erase = 1'b1;
        cmd_next.addr  = block_base_w;
        state_next     = ST_ERASE_WAIT;
      end
      // row erase time
      ST_ERASE_WAIT: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == ERASE_LAST) begin
          state_next = ST_FINISH;
        end
      end
      // one latch takes the data pair, then stop or commit
      ST_LOAD: begin
        cnt_next = '0;
        if (latch_only_reg) begin
          state_next = ST_FINISH;
        end else begin
          state_next = ST_PROG_STREAM;
        end
      end
      // stream the latch block out one word per cycle
      ST_PROG_STREAM: begin
        // every latch goes out, with no erase command beside it
        cmd_next.prog = 1'b1;
        cmd_next.addr = block_base_w | PADDR_W'(stream_idx_w);
        cmd_next.data = latch_word_w;
        cnt_next      = cnt_reg + 1'b1;
        if (cnt_reg == WORD_LAST) begin
          cnt_next   = '0;
          state_next = ST_PROG_WAIT;
        end
      end
      // programming time; latches clear on its last cycle
      ST_PROG_WAIT: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == PROG_LAST) begin
          state_next = ST_FINISH;
        end
      end
      // one cycle in which trigger and erase select clear
      ST_FINISH: begin
        cnt_next   = '0;
        state_next = ST_IDLE;
      end
      // unused codes fall back to idle
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // stall covers the long phases only
  // setup, load and finish leave the core running: it gets its two idle
  // slots behind the trigger (a commit also its third, in load) and resumes on the next after the stall
  wire stall_next_w = state_next == ST_ERASE
                      || state_next == ST_ERASE_WAIT
                      || state_next == ST_PROG_STREAM
                      || state_next == ST_PROG_WAIT;

  // state, counter, command and stall flops
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      cmd_reg   <= '0;
      stall_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cmd_reg   <= cmd_next;
      stall_reg <= stall_next_w;
    end
  end

  // unlock key state; a reset always leaves the port locked
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      key_reg <= KEY_LOCKED;
    end else begin
      key_reg <= key_next;
    end
  end

  // address and data pair, frozen while an operation runs
  // writes while busy are dropped so the running command cannot change
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      addr_low_reg  <= REG_RESET;
      addr_high_reg <= '0;
      data_low_reg  <= REG_RESET;
      data_high_reg <= '0;
    end else if (idle_w) begin
      if (wr_addr_lo_w) addr_low_reg  <= wd_w;
      if (wr_addr_hi_w) addr_high_reg <= wd_w[ADDR_HIGH_W-1:0];
      if (wr_data_lo_w) data_low_reg  <= wd_w;
      if (wr_data_hi_w) data_high_reg <= wd_w[DATA_HIGH_W-1:0];
    end
  end

  // control bits; trigger and erase select clear in hardware at the end
  // software cannot clear the trigger; only the end of an operation does
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      trigger_reg    <= 1'b0;
      permit_reg     <= 1'b0;
      erase_sel_reg  <= 1'b0;
      latch_only_reg <= 1'b0;
      config_sel_reg <= 1'b0;
      prog_space_reg <= 1'b0;
    end else if (done_w) begin
      trigger_reg   <= 1'b0;
      erase_sel_reg <= 1'b0;
    end else if (idle_w && wr_ctl_w) begin
      trigger_reg    <= trig_ok_w;
      permit_reg     <= wd_w[CTL_PERMIT_BIT];
      erase_sel_reg  <= wd_w[CTL_ERASE_BIT];
      latch_only_reg <= wd_w[CTL_LATCH_BIT];
      config_sel_reg <= wd_w[CTL_CONFIG_BIT];
      prog_space_reg <= wd_w[CTL_PROGSPACE_BIT];
    end
  end

  // read selection
  wire [REG_DATA_W-1:0] ctl_rd_w = {prog_space_reg, // bit 7
                                    config_sel_reg, // bit 6
                                    2'h0,           // bits 5 and 4
                                    latch_only_reg, // bit 3
                                    erase_sel_reg,  // bit 2
                                    permit_reg,     // bit 1
                                    trigger_reg};   // bit 0
  wire [REG_DATA_W-1:0] rd_sel_w =
    (reg_req_i.addr == OFS_ADDR_LOW)  ? addr_low_reg :
    (reg_req_i.addr == OFS_ADDR_HIGH) ? {1'b0, addr_high_reg} :
    (reg_req_i.addr == OFS_DATA_LOW)  ? data_low_reg :
    (reg_req_i.addr == OFS_DATA_HIGH) ? {2'h0, data_high_reg} :
    (reg_req_i.addr == OFS_CONTROL)   ? ctl_rd_w :
                                        8'h00;

  // read data stand one cycle after the strobe, zero otherwise
  // clearing it after one cycle keeps stale data off the port
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= REG_RESET;
    end else if (reg_req_i.re) begin
      rdata_reg <= rd_sel_w;
    end else begin
      rdata_reg <= REG_RESET;
    end
  end

  // write latch bank
  // the bank reads by stream index while loads use the address index
  flash_write_latches #(
    .COUNT (LATCHES),
    .IDX_W (IDX_W)
  ) u_latches (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b),
    .load_i      (latch_load_w),
    .load_idx_i  (latch_idx_w),
    .load_word_i (data_word_w),
    .clear_all_i (latch_clear_w),
    .rd_idx_i    (stream_idx_w),
    .rd_word_o   (latch_word_w)
  );

  // outputs
  // the core sees stall on the same edge as the state that asks for it
  assign reg_rdata_o  = rdata_reg;
  assign core_stall_o = stall_reg;
  assign flash_cmd_o  = cmd_reg;

endmodule

// ==== pkg/flash_seq_pkg.sv ====
// constants, field layout and types for the program flash sequencer
// assumes a 200 MHz core clock and an 8-bit register port
package flash_seq_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int ERASE_TIME_MS = 2;
  localparam int ERASE_CYCLES  = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_TIME_MS  = 2;
  localparam int PROG_CYCLES   = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SETUP_CYCLES  = 2;
  localparam int CNT_W         = 20;

  // widths and sizes
  localparam int REG_ADDR_W  = 3;
  localparam int REG_DATA_W  = 8;
  localparam int PADDR_W     = 15;
  localparam int PWORD_W     = 14;
  localparam int DATA_HIGH_W = PWORD_W - REG_DATA_W;
  localparam int ADDR_HIGH_W = PADDR_W - REG_DATA_W;
  localparam int LATCH_COUNT = 32;

  // register offsets
  localparam logic [REG_ADDR_W-1:0] OFS_ADDR_LOW  = 3'h0;
  localparam logic [REG_ADDR_W-1:0] OFS_ADDR_HIGH = 3'h1;
  localparam logic [REG_ADDR_W-1:0] OFS_DATA_LOW  = 3'h2;
  localparam logic [REG_ADDR_W-1:0] OFS_DATA_HIGH = 3'h3;
  localparam logic [REG_ADDR_W-1:0] OFS_CONTROL   = 3'h4;
  localparam logic [REG_ADDR_W-1:0] OFS_UNLOCK    = 3'h5;

  // control register bit positions
  localparam int CTL_TRIGGER_BIT   = 0;
  localparam int CTL_PERMIT_BIT    = 1;
  localparam int CTL_ERASE_BIT     = 2;
  localparam int CTL_LATCH_BIT     = 3;
  localparam int CTL_CONFIG_BIT    = 6;
  localparam int CTL_PROGSPACE_BIT = 7;

  // key values and reset values
  localparam logic [REG_DATA_W-1:0] KEY_FIRST   = 8'h55;
  localparam logic [REG_DATA_W-1:0] KEY_SECOND  = 8'haa;
  localparam logic [PWORD_W-1:0]    LATCH_RESET = 14'h3fff;
  localparam logic [REG_DATA_W-1:0] REG_RESET   = 8'h00;

  // register port request
  typedef struct packed {
    logic                  we;
    logic                  re;
    logic [REG_ADDR_W-1:0] addr;
    logic [REG_DATA_W-1:0] wdata;
  } reg_req_t;

  // command toward the flash array
  typedef struct packed {
    logic               erase;
    logic               prog;
    logic [PADDR_W-1:0] addr;
    logic [PWORD_W-1:0] data;
  } flash_cmd_t;

  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_HALF,
    KEY_OPEN
  } key_state_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOAD,
    ST_ERASE,
    ST_ERASE_WAIT,
    ST_PROG_STREAM,
    ST_PROG_WAIT,
    ST_FINISH
  } seq_state_t;

endpackage

// ==== design/flash_write_latches.sv ====
// bank of program flash write latches
// assumes one writer; clear_all_i and load_i never come in one cycle
`timescale 1ns/1ps
module flash_write_latches
  import flash_seq_pkg::*;
#(
  parameter int COUNT = LATCH_COUNT,
  parameter int IDX_W = $clog2(LATCH_COUNT)
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // load and clear
  input  wire logic               load_i,
  input  wire logic [IDX_W-1:0]   load_idx_i,
  input  wire logic [PWORD_W-1:0] load_word_i,
  input  wire logic               clear_all_i,
  // read
  input  wire logic [IDX_W-1:0]   rd_idx_i,
  output logic      [PWORD_W-1:0] rd_word_o
);

  logic [PWORD_W-1:0] latch_reg [COUNT];

  // read selection
  assign rd_word_o = latch_reg[rd_idx_i];

  // latches load one word, or all return to the erased value
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < COUNT; i++) begin
        latch_reg[i] <= LATCH_RESET;
      end
    end else if (clear_all_i) begin
      for (int i = 0; i < COUNT; i++) begin
        latch_reg[i] <= LATCH_RESET;
      end
    end else if (load_i) begin
      latch_reg[load_idx_i] <= load_word_i;
    end
  end

endmodule

// ==== testbench/flash_row_sequencer_monitor.sv ====
// port checker for the flash sequencer, bound to every instance
// assumes the package constants and a single clock domain
`timescale 1ns/1ps
module flash_row_sequencer_monitor
  import flash_seq_pkg::*;
#(
  parameter int LATCHES     = LATCH_COUNT,
  parameter int ERASE_COUNT = ERASE_CYCLES,
  parameter int PROG_COUNT  = PROG_CYCLES
) (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_b_i,
  // watched ports
  input wire reg_req_t              reg_req_i,
  input wire logic [REG_DATA_W-1:0] reg_rdata_o,
  input wire logic                  core_stall_o,
  input wire flash_cmd_t            flash_cmd_o
);
  localparam int MIN_HOLD = ERASE_COUNT < PROG_COUNT ? ERASE_COUNT
                                                     : PROG_COUNT;
  localparam int MAX_HOLD = ERASE_COUNT + PROG_COUNT + LATCHES + 8;
  logic [1:0]  key_reg;
  logic [7:0]  age_reg;
  int unsigned prog_run_reg;
  int unsigned stall_run_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // decode of key and trigger writes
  wire             ctl_wr = reg_req_i.we && reg_req_i.addr == OFS_CONTROL;
  wire             key_wr = reg_req_i.we && reg_req_i.addr == OFS_UNLOCK;
  wire [7:0]       wd     = reg_req_i.wdata;
  wire             go_ok  = ctl_wr && key_reg == 2'h2 && wd[0] && wd[1]
                            && wd[7] && !wd[6];

  // key tracker, trigger age and run lengths
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      key_reg       <= 2'h0;
      age_reg       <= 8'hff;
      prog_run_reg  <= 0;
      stall_run_reg <= 0;
    end else begin
      key_reg <= (key_wr && wd == KEY_FIRST) ? 2'h1 :
                 (key_wr && wd == KEY_SECOND && key_reg == 2'h1) ? 2'h2 :
                 reg_req_i.we ? 2'h0 : key_reg;
      age_reg <= go_ok ? 8'h00 :
                 (age_reg == 8'hff ? age_reg : age_reg + 8'h01);
      prog_run_reg  <= flash_cmd_o.prog ? prog_run_reg + 1 : 0;
      stall_run_reg <= core_stall_o ? stall_run_reg + 1 : 0;
    end
  end

  erase_row_base_a: assert property (
    flash_cmd_o.erase |-> flash_cmd_o.addr % LATCHES == 0)
    else $error("erase address not on a row base");
  key_gate_a: assert property (
    $rose(core_stall_o) |-> age_reg <= 8'h08)
    else $error("stall began without an unlocked trigger");
  erase_start_a: assert property (
    go_ok && wd[2] |-> ##[3:8] flash_cmd_o.erase && core_stall_o)
    else $error("unlocked erase trigger did not start an erase");
  setup_run_a: assert property (
    ctl_wr && wd[0] |-> ##1 !core_stall_o ##1 !core_stall_o)
    else $error("core stalled inside the two setup cycles");
  stall_hold_a: assert property (
    $fell(core_stall_o) |-> stall_run_reg >= MIN_HOLD
                            && stall_run_reg <= MAX_HOLD)
    else $error("stall length out of range");
  no_auto_erase_a: assert property (
    !(flash_cmd_o.erase && flash_cmd_o.prog))
    else $error("erase issued together with program");
  block_align_a: assert property (
    flash_cmd_o.prog |-> flash_cmd_o.addr % LATCHES == prog_run_reg)
    else $error("program address leaves the latch block");
  latch_only_a: assert property (
    go_ok && wd[3] && !wd[2] |-> ##1 (!core_stall_o && !flash_cmd_o.prog
                                      && !flash_cmd_o.erase) [*6])
    else $error("latch load started a flash operation");
  commit_start_a: assert property (
    go_ok && !wd[3] && !wd[2] |-> ##[3:8] flash_cmd_o.prog)
    else $error("commit trigger did not start programming");
  full_block_a: assert property (
    $fell(flash_cmd_o.prog) |-> prog_run_reg == LATCHES)
    else $error("commit did not program the whole block");

  // main scenarios reached
  erase_seen_c: cover property (flash_cmd_o.erase);
  commit_seen_c: cover property ($fell(flash_cmd_o.prog));
  load_seen_c: cover property (go_ok && wd[3]);
endmodule

bind flash_row_sequencer flash_row_sequencer_monitor #(
  .LATCHES(LATCHES), .ERASE_COUNT(ERASE_COUNT), .PROG_COUNT(PROG_COUNT)
) i_mon (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .core_stall_o(core_stall_o),
  .flash_cmd_o(flash_cmd_o)
);

// ==== testbench/core_master_model.sv ====
// processor core model driving the register port of the sequencer
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/1ps
module core_master_model
  import flash_seq_pkg::*;
(
  // clock
  input  wire logic                  clk_i,
  // register port
  output reg_req_t                   req_o,
  input  wire logic [REG_DATA_W-1:0] rdata_i
);
  int gap = 0;
  initial req_o = '0;

  // idle slot; address and data carry junk so nothing leans on them
  task automatic nop();
    req_o <= '{we: 1'b0, re: 1'b0, addr: ~req_o.addr, wdata: 8'($urandom)};
    @(posedge clk_i);
  endtask

  // one write cycle, then optional idle slots for a slow core
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req_o <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    repeat (gap) nop();
  endtask

  // one read cycle; data are taken in the slot after it
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    req_o <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'($urandom)};
    @(posedge clk_i);
    nop();
    d = rdata_i;
  endtask

  // key pair, trigger write and the two idle slots behind it
  task automatic go(input logic [7:0] c);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CONTROL, c);
    nop();
    nop();
  endtask
endmodule

// ==== testbench/tb_program_flash_row_erase_and_write.sv ====
// self-checking bench for the flash row sequencer
// assumes the core model as the only register port master
`timescale 1ns/1ps
module tb_program_flash_row_erase_and_write
  import flash_seq_pkg::*;
;
  localparam int EC = 20;
  localparam int PC = 20;
  logic       clk_i   = 1'b0;
  logic       rst_b_i = 1'b0;
  reg_req_t   req;
  logic [7:0] rdata;
  logic       stall;
  flash_cmd_t cmd;
  int         fails   = 0;
  int         checked = 0;
  int         stall_n = 0;
  int         qk[$];
  int         qa[$];
  int         qd[$];
  int         lat[LATCH_COUNT];
  logic [7:0] v;

  always #2.5 clk_i = ~clk_i;

  flash_row_sequencer #(.LATCHES(LATCH_COUNT), .ERASE_COUNT(EC),
    .PROG_COUNT(PC)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .core_stall_o(stall),
    .flash_cmd_o(cmd));
  core_master_model i_core (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // every flash command against the reference queues
  always @(posedge clk_i) begin
    if (stall === 1'b1) stall_n++;
    if (cmd.erase === 1'b1 || cmd.prog === 1'b1) begin
      if (qk.size() == 0) chk("stray command", 0, 1);
      else begin
        chk("command kind", qk[0], {cmd.erase, cmd.prog});
        chk("command addr", qa.pop_front(), cmd.addr);
        if (qk.pop_front() == 1) chk("command data", qd[0], cmd.data);
        void'(qd.pop_front());
      end
    end
  end

  // poll control until the trigger drops, then compare it
  task automatic wait_idle(input logic [7:0] e);
    int n = 0;
    v = 8'h01;
    while (v[0] !== 1'b0 && n < 400) begin
      i_core.rd(OFS_CONTROL, v);
      n++;
    end
    if (n == 400) begin
      fails++;
      summarize();
    end
    chk("control", e, v);
  endtask

  // reset values, unmapped place, held address and data registers
  task automatic t_regs();
    logic [7:0] w [4];
    logic [7:0] m [4] = '{8'hff, 8'h7f, 8'hff, 8'h3f};
    for (int k = 0; k < 8; k++) begin
      i_core.rd(3'(k), v);
      chk("reset value", REG_RESET, v);
    end
    foreach (w[k]) begin
      w[k] = 8'($urandom);
      i_core.wr(3'(k), w[k]);
    end
    i_core.wr(3'h6, 8'hff);
    for (int k = 0; k < 8; k++) begin
      i_core.rd(3'(k), v);
      chk("readback", k < 4 ? w[k % 4] & m[k % 4] : 8'h00, v);
    end
  endtask

  // erase three random rows
  task automatic t_erase();
    logic [14:0] a;
    repeat (3) begin
      a = 15'($urandom);
      i_core.wr(OFS_ADDR_LOW, a[7:0]);
      i_core.wr(OFS_ADDR_HIGH, {1'b0, a[14:8]});
      i_core.wr(OFS_CONTROL, 8'h86);
      qk.push_back(2);
      qa.push_back(int'(a) / LATCH_COUNT * LATCH_COUNT);
      qd.push_back(0);
      stall_n = 0;
      i_core.go(8'h87);
      wait_idle(8'h82);
      chk("stall span", 1, stall_n >= EC && stall_n <= EC + 8);
      chk("erase issued", 0, qk.size());
    end
  endtask

  // triggers without a proper key or setup must be ignored
  task automatic t_refuse();
    logic [7:0] ex [5] = '{8'h86, 8'h86, 8'h86, 8'h84, 8'hc6};
    for (int k = 0; k < 5; k++) begin
      i_core.wr(OFS_CONTROL, 8'h86);
      i_core.wr(OFS_UNLOCK, k == 1 ? KEY_SECOND : KEY_FIRST);
      if (k > 0) i_core.wr(OFS_UNLOCK, k == 1 ? KEY_FIRST : KEY_SECOND);
      if (k == 0 || k == 2) i_core.wr(OFS_DATA_LOW, 8'h00);
      i_core.wr(OFS_CONTROL, k == 3 ? 8'h85 : (k == 4 ? 8'hc7 : 8'h87));
      repeat (8) i_core.nop();
      i_core.rd(OFS_CONTROL, v);
      chk("refused trigger", ex[k], v);
    end
  endtask

  // load n latches of a random block, then commit it
  task automatic t_block(input int n);
    logic [14:0] b;
    logic [13:0] d;
    b = 15'($urandom) & ~15'(LATCH_COUNT - 1);
    i_core.wr(OFS_CONTROL, 8'h8a);
    for (int i = 0; i < n; i++) begin
      d = 14'($urandom);
      if (i == n - 1) i_core.wr(OFS_CONTROL, 8'h82);
      i_core.wr(OFS_ADDR_LOW, 8'(b + 15'(i)));
      i_core.wr(OFS_ADDR_HIGH, 8'((b + 15'(i)) >> 8));
      i_core.wr(OFS_DATA_LOW, d[7:0]);
      i_core.wr(OFS_DATA_HIGH, {2'b00, d[13:8]});
      lat[i] = d;
      for (int j = 0; j < LATCH_COUNT && i == n - 1; j++) begin
        qk.push_back(1);
        qa.push_back(b + j);
        qd.push_back(lat[j]);
        lat[j] = LATCH_RESET;
      end
      i_core.go(i == n - 1 ? 8'h83 : 8'h8b);
      wait_idle(i == n - 1 ? 8'h82 : 8'h8a);
    end
    chk("block drained", 0, qk.size());
  endtask

  initial begin
    void'($urandom(79829));
    foreach (lat[j]) lat[j] = LATCH_RESET;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs();
    $display("register test done");
    t_erase();
    $display("erase test done");
    t_refuse();
    $display("refusal test done");
    t_block(LATCH_COUNT);
    t_block(1);
    i_core.gap = 2;
    t_block($urandom_range(LATCH_COUNT - 1, 2));
    $display("block write test done");
    summarize();
  end

  // hang guard
  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule
